/* File: core/tfid_pkg.sv */
// Constants and types for the technology-function interrupt block
package tfid_pkg;
    // Register word addresses (byte address, one 32-bit word each)
    localparam logic [7:0] TFID_ADDR_CTRL   = 8'h00;
    localparam logic [7:0] TFID_ADDR_STATUS = 8'h04;
    localparam logic [7:0] TFID_ADDR_DETAIL = 8'h08;
    localparam logic [7:0] TFID_ADDR_REC0   = 8'h0c;
    localparam logic [7:0] TFID_ADDR_ACK    = 8'h10;
    localparam logic [7:0] TFID_ADDR_PEND   = 8'h14;

    // Control register fields
    localparam int TFID_CTRL_FUNC_LSB = 0;
    localparam int TFID_CTRL_OPT_BIT  = 2;
    localparam int TFID_CTRL_OUTEN_BIT = 3;
    localparam int TFID_CTRL_DIAGEN_BIT = 4;
    localparam logic [4:0] TFID_CTRL_RESET = 5'h00;

    // Acknowledge register bits
    localparam int TFID_ACK_PROC_BIT = 0;
    localparam int TFID_ACK_DIAG_BIT = 1;

    // Channel layout: 16 input edges, then 3 measurement channels
    localparam int TFID_NUM_EDGE = 16;
    localparam int TFID_NUM_MEAS = 3;
    localparam int TFID_NUM_CH   = 19;
    localparam int TFID_CH_W     = 5;

    // Detail word positions of end-of-measurement events
    localparam logic [4:0] TFID_DET_MEAS0_BIT = 5'h10;
    localparam logic [4:0] TFID_DET_MEAS1_BIT = 5'h14;
    localparam logic [4:0] TFID_DET_MEAS2_BIT = 5'h18;

    // Record 0 field values
    localparam logic [3:0] TFID_CLASS_DIGITAL = 4'hf;
    localparam int TFID_REC_FAIL_BIT  = 0;
    localparam int TFID_REC_EXT_BIT   = 2;
    localparam int TFID_REC_CHAN_BIT  = 3;
    localparam int TFID_REC_INFO_BIT  = 12;
    localparam logic [7:0] TFID_REC_LOST_BYTE = 8'h40;
    localparam logic [7:0] TFID_REC_NONE_BYTE = 8'h00;

    // Diagnostic queue depth
    localparam int TFID_QUEUE_DEPTH = 32;
    localparam int TFID_QUEUE_AW    = 5;

    typedef enum logic [1:0]
    {
        TFID_FUNC_NONE  = 2'h0,
        TFID_FUNC_COUNT = 2'h1,
        TFID_FUNC_FREQ  = 2'h2,
        TFID_FUNC_PWM   = 2'h3
    } tfid_func_t;

    typedef enum logic [1:0]
    {
        TFID_SVC_IDLE = 2'b01,
        TFID_SVC_BUSY = 2'b10
    } tfid_svc_t;
endpackage

/* File: core/tfid_edge_sync.sv */
// Two-flop synchroniser with any-edge detection per input pin
`timescale 1ns/1ps
module tfid_edge_sync
    import tfid_pkg::*;
#(
    parameter int W = 16
)
(
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] edge_out
);
    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] last;

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            // First flop feeds only the second one
            always_ff @(posedge clk)
            begin
                if (srst)
                begin
                    meta[i]   <= 1'b0;
                    stable[i] <= 1'b0;
                    last[i]   <= 1'b0;
                end
                else
                begin
                    meta[i]   <= pin_in[i];
                    stable[i] <= meta[i];
                    last[i]   <= stable[i];
                end
            end
            // Both edges count as an input event
            assign edge_out[i] = stable[i] ^ last[i];
        end
    endgenerate
endmodule

/* File: core/tfid_diag_queue.sv */
// Order-keeping queue of pending diagnostic requests
`timescale 1ns/1ps
module tfid_diag_queue
    import tfid_pkg::*;
#(
    parameter int W = 6
)
(
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         push,
    input  wire logic [W-1:0] din,
    input  wire logic         pop,
    output logic      [W-1:0] dout,
    output logic              empty,
    output logic              full
);
    logic [W-1:0]            mem [TFID_QUEUE_DEPTH];
    logic [TFID_QUEUE_AW:0]  wr_ptr;
    logic [TFID_QUEUE_AW:0]  rd_ptr;

    // Extra pointer bit tells full from empty
    assign empty = (wr_ptr == rd_ptr);
    assign full  = (wr_ptr[TFID_QUEUE_AW] != rd_ptr[TFID_QUEUE_AW]) &&
                   (wr_ptr[TFID_QUEUE_AW-1:0] == rd_ptr[TFID_QUEUE_AW-1:0]);
    assign dout  = mem[rd_ptr[TFID_QUEUE_AW-1:0]];

    // Storage has no reset; pointers guard it
    always_ff @(posedge clk)
    begin
        if (push && !full)
            mem[wr_ptr[TFID_QUEUE_AW-1:0]] <= din;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push && !full)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop && !empty)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

/* File: core/tfid_irq_ctrl.sv */
// Process and diagnostic interrupt sequencing for technology functions
// Function
// - Frequency mode: detail bytes 8 and 9 flag edges on inputs 0.x, 1.x.
// - Detail byte 10 bit 0 marks end of measurement channel 0.
// - Detail byte 10 bit 4 marks end of measurement channel 1.
// - Detail byte 11 bit 0 marks end of measurement channel 2.
// - Diagnostics need a selected function and the combined option.
// - Global diagnostic enable comes from configuration record 7Fh; here it is control register bit 4.
// - Repeat of the serviced event raises a diagnostic, not a process.
// - Incoming diagnostic pre-empts the running process handler.
// - Other channels' events during diagnostic service are held.
// - After service: held diagnostics in order, then held processes.
// - Channel in or queued for diagnostic discards its process events.
// - Process handler done after incoming raises an outgoing diagnostic.
// - Events between incoming and outgoing of a channel are discarded.
// - Fault lamp lit from first incoming to last outgoing diagnostic.
// - Every diagnostic dispatch logs cause and module address.
// - Last diagnostic event stays readable with diagnostics disabled.
// - Record 0 is in the handler detail word before diagnostic entry; here it is in the REC0 word, written on the edge the handler rises.
// - Record 0 byte 0: bit 0 failure, 2 external, 3 channel error.
// - Record 0 byte 1: class 1111b digital, bit 4 channel info.
// - Incoming record: byte 2 zero, byte 3 bit 6 process lost.
// - Outgoing only if enable still set; bytes 2 and 3 are 00h.
// - Record 0 layout is the same for every function.
// - Process interrupts need output enable and the combined option.
// - Pulse-width function never raises process interrupts.
`timescale 1ns/1ps
module tfid_irq_ctrl
    import tfid_pkg::*;
#(
    parameter logic [15:0] MODULE_ADDR = 16'h0000
)
(
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic [TFID_NUM_EDGE-1:0] din_pin,
    input  wire logic [TFID_NUM_MEAS-1:0] meas_done,
    input  wire logic                    module_fail,
    input  wire logic                    ext_error,
    input  wire logic [7:0]              addr,
    input  wire logic [31:0]             wdata,
    input  wire logic                    wr_en,
    input  wire logic                    rd_en,
    output logic      [31:0]             rdata,
    output logic                         process_event_handler,
    output logic                         fault_event_handler,
    output logic                         system_fault_lamp,
    output logic                         log_valid,
    output logic      [15:0]             log_cause,
    output logic      [15:0]             log_addr
);
    logic [4:0]              ctrl;
    tfid_func_t              func;
    tfid_svc_t               proc_st;
    tfid_svc_t               diag_st;
    logic [TFID_CH_W-1:0]    proc_ch;
    logic [TFID_CH_W-1:0]    diag_ch;
    logic                    diag_out;
    logic [TFID_NUM_CH-1:0]  pend;
    logic [TFID_NUM_CH-1:0]  in_diag;
    logic [31:0]             detail;
    logic [31:0]             rec0;
    logic [TFID_NUM_EDGE-1:0] edge_ev;
    logic [TFID_NUM_CH-1:0]  ev;
    logic [TFID_NUM_CH-1:0]  ev_ok;
    logic                    proc_ok;
    logic                    diag_ok;
    logic                    proc_ack;
    logic                    diag_ack;
    logic                    repeat_hit;
    logic                    inc_push;
    logic                    out_push;
    logic                    q_push;
    logic [TFID_CH_W:0]      q_din;
    logic [TFID_CH_W:0]      q_dout;
    logic                    q_empty;
    logic                    q_full;
    logic                    q_pop;
    logic                    proc_go;
    logic [TFID_CH_W-1:0]    pick_ch;
    logic [TFID_NUM_CH-1:0]  next_pend;
    logic [TFID_NUM_CH-1:0]  next_in_diag;

    // Pin edges pass two flops before anything reads them
    tfid_edge_sync #(
        .W (TFID_NUM_EDGE)
    ) u_sync (
        .clk      (clk),
        .srst     (srst),
        .pin_in   (din_pin),
        .edge_out (edge_ev)
    );

    // Detail word position of each channel
    function automatic logic [4:0] det_bit(input logic [TFID_CH_W-1:0] ch);
        logic [4:0] pos;
        pos = ch;
        if (ch == 5'd16)
            pos = TFID_DET_MEAS0_BIT;
        else if (ch == 5'd17)
            pos = TFID_DET_MEAS1_BIT;
        else if (ch == 5'd18)
            pos = TFID_DET_MEAS2_BIT;
        return pos;
    endfunction

    // Configuration decode
    assign func = tfid_func_t'(ctrl[TFID_CTRL_FUNC_LSB +: 2]);
    assign proc_ok = ((func == TFID_FUNC_COUNT) || (func == TFID_FUNC_FREQ))
                     && ctrl[TFID_CTRL_OPT_BIT]
                     && ctrl[TFID_CTRL_OUTEN_BIT];
    assign diag_ok = (func != TFID_FUNC_NONE)
                     && ctrl[TFID_CTRL_OPT_BIT]
                     && ctrl[TFID_CTRL_DIAGEN_BIT];

    // Measurement ends only exist in frequency mode
    assign ev[TFID_NUM_EDGE-1:0] = edge_ev;
    assign ev[TFID_NUM_CH-1:TFID_NUM_EDGE] =
        (func == TFID_FUNC_FREQ) ? meas_done : '0;

    // Channels under diagnostic drop every event
    assign ev_ok = proc_ok ? (ev & ~in_diag) : '0;

    // Handler completion writes
    assign proc_ack = wr_en && (addr == TFID_ADDR_ACK)
                      && wdata[TFID_ACK_PROC_BIT]
                      && (proc_st == TFID_SVC_BUSY)
                      && (diag_st == TFID_SVC_IDLE);
    assign diag_ack = wr_en && (addr == TFID_ADDR_ACK)
                      && wdata[TFID_ACK_DIAG_BIT]
                      && (diag_st == TFID_SVC_BUSY);

    // Same event again while its handler runs
    assign repeat_hit = (proc_st == TFID_SVC_BUSY) && !proc_ack
                        && ev_ok[proc_ch];
    assign inc_push = repeat_hit && diag_ok && !q_full;
    assign out_push = proc_ack && in_diag[proc_ch] && diag_ok
                      && !q_full;
    assign q_push = inc_push || out_push;
    assign q_din = {out_push, proc_ch};

    // Diagnostics drain first, processes only when queue is empty
    assign q_pop = (diag_st == TFID_SVC_IDLE) && !q_empty;
    assign proc_go = (proc_st == TFID_SVC_IDLE)
                     && (diag_st == TFID_SVC_IDLE)
                     && q_empty && !q_push && (|pend);

    tfid_diag_queue #(
        .W (TFID_CH_W + 1)
    ) u_queue (
        .clk   (clk),
        .srst  (srst),
        .push  (q_push),
        .din   (q_din),
        .pop   (q_pop),
        .dout  (q_dout),
        .empty (q_empty),
        .full  (q_full)
    );

    // Lowest pending channel is served first
    always_comb
    begin
        pick_ch = '0;
        for (int c = TFID_NUM_CH - 1; c >= 0; c--)
        begin
            if (pend[c])
                pick_ch = TFID_CH_W'(c);
        end
    end

    // Pending mask: set beats clear, others held during service
    always_comb
    begin
        next_pend = pend;
        if (proc_go)
            next_pend[pick_ch] = 1'b0;
        for (int c = 0; c < TFID_NUM_CH; c++)
        begin
            if (ev_ok[c] && !(repeat_hit && (proc_ch == TFID_CH_W'(c))))
                next_pend[c] = 1'b1;
        end
    end

    // Diagnostic episode per channel
    always_comb
    begin
        next_in_diag = in_diag;
        if (proc_ack && !out_push)
            next_in_diag[proc_ch] = 1'b0;
        if (q_pop && q_dout[TFID_CH_W])
            next_in_diag[q_dout[TFID_CH_W-1:0]] = 1'b0;
        if (inc_push)
            next_in_diag[proc_ch] = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pend    <= '0;
            in_diag <= '0;
        end
        else
        begin
            pend    <= next_pend;
            in_diag <= next_in_diag;
        end
    end

    // Lamp covers first incoming to last outgoing
    always_ff @(posedge clk)
    begin
        if (srst)
            system_fault_lamp <= 1'b0;
        else
            system_fault_lamp <= (|next_in_diag) && (system_fault_lamp ||
                (q_pop && !q_dout[TFID_CH_W]));
    end

    // Process handler service state
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            proc_st <= TFID_SVC_IDLE;
            proc_ch <= '0;
            detail  <= '0;
        end
        else
        begin
            unique case (proc_st)
                TFID_SVC_IDLE:
                begin
                    if (proc_go)
                    begin
                        proc_st <= TFID_SVC_BUSY;
                        proc_ch <= pick_ch;
                        detail  <= 32'h1 << det_bit(pick_ch);
                    end
                end
                TFID_SVC_BUSY:
                begin
                    if (proc_ack)
                        proc_st <= TFID_SVC_IDLE;
                end
            endcase
        end
    end

    // Diagnostic handler service state
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            diag_st  <= TFID_SVC_IDLE;
            diag_ch  <= '0;
            diag_out <= 1'b0;
        end
        else
        begin
            unique case (diag_st)
                TFID_SVC_IDLE:
                begin
                    if (q_pop)
                    begin
                        diag_st  <= TFID_SVC_BUSY;
                        diag_ch  <= q_dout[TFID_CH_W-1:0];
                        diag_out <= q_dout[TFID_CH_W];
                    end
                end
                TFID_SVC_BUSY:
                begin
                    if (diag_ack)
                        diag_st <= TFID_SVC_IDLE;
                end
            endcase
        end
    end

    // Record 0 written in the same edge the handler request rises
    always_ff @(posedge clk)
    begin
        if (srst)
            rec0 <= '0;
        else if (q_pop)
        begin
            rec0 <= '0;
            rec0[TFID_REC_FAIL_BIT] <= module_fail;
            rec0[TFID_REC_EXT_BIT]  <= ext_error;
            rec0[TFID_REC_CHAN_BIT] <= !q_dout[TFID_CH_W];
            rec0[11:8] <= TFID_CLASS_DIGITAL;
            rec0[TFID_REC_INFO_BIT] <= 1'b1;
            rec0[23:16] <= TFID_REC_NONE_BYTE;
            rec0[31:24] <= q_dout[TFID_CH_W] ? TFID_REC_NONE_BYTE
                                             : TFID_REC_LOST_BYTE;
        end
        else if (repeat_hit && !diag_ok && (diag_st == TFID_SVC_IDLE))
        begin
            // No interrupt, but software can still see the event
            rec0 <= '0;
            rec0[TFID_REC_FAIL_BIT] <= module_fail;
            rec0[TFID_REC_EXT_BIT]  <= ext_error;
            rec0[TFID_REC_CHAN_BIT] <= 1'b1;
            rec0[11:8] <= TFID_CLASS_DIGITAL;
            rec0[TFID_REC_INFO_BIT] <= 1'b1;
            rec0[31:24] <= TFID_REC_LOST_BYTE;
        end
    end

    // One log entry per diagnostic handler entry
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            log_valid <= 1'b0;
            log_cause <= '0;
            log_addr  <= '0;
        end
        else
        begin
            log_valid <= q_pop;
            if (q_pop)
            begin
                log_cause <= {(q_dout[TFID_CH_W] ? TFID_REC_NONE_BYTE
                                                 : TFID_REC_LOST_BYTE),
                              4'h0, !q_dout[TFID_CH_W], ext_error,
                              1'b0, module_fail};
                log_addr  <= MODULE_ADDR;
            end
        end
    end

    // Pre-empted process request is hidden while diagnostics run
    assign process_event_handler = (proc_st == TFID_SVC_BUSY)
                                   && (diag_st == TFID_SVC_IDLE);
    assign fault_event_handler = (diag_st == TFID_SVC_BUSY);

    // Control register write
    always_ff @(posedge clk)
    begin
        if (srst)
            ctrl <= TFID_CTRL_RESET;
        else if (wr_en && (addr == TFID_ADDR_CTRL))
            ctrl <= wdata[4:0];
    end

    // Read data next cycle; reads change no state
    always_ff @(posedge clk)
    begin
        if (srst)
            rdata <= '0;
        else if (rd_en)
        begin
            unique case (addr)
                TFID_ADDR_CTRL:   rdata <= {27'h0, ctrl};
                TFID_ADDR_STATUS: rdata <= {11'h0, diag_ch, 3'h0, proc_ch,
                                            4'h0, system_fault_lamp,
                                            diag_out, fault_event_handler,
                                            process_event_handler};
                TFID_ADDR_DETAIL: rdata <= detail;
                TFID_ADDR_REC0:   rdata <= rec0;
                TFID_ADDR_PEND:   rdata <= {13'h0, pend};
                default:          rdata <= '0;
            endcase
        end
        else
            rdata <= '0;
    end
endmodule

/* File: bench/tfid_irq_ctrl_asserts.sv */
// Port-level checker for the technology-function interrupt block
`timescale 1ns/1ps
module tfid_irq_chk
    import tfid_pkg::*;
#(
    parameter logic [15:0] MODULE_ADDR = 16'h0000
)
(
    input  wire logic                     clk,
    input  wire logic                     srst,
    input  wire logic [TFID_NUM_EDGE-1:0] din_pin,
    input  wire logic [TFID_NUM_MEAS-1:0] meas_done,
    input  wire logic                     module_fail,
    input  wire logic                     ext_error,
    input  wire logic [7:0]               addr,
    input  wire logic [31:0]              wdata,
    input  wire logic                     wr_en,
    input  wire logic                     rd_en,
    input  wire logic [31:0]              rdata,
    input  wire logic                     process_event_handler,
    input  wire logic                     fault_event_handler,
    input  wire logic                     system_fault_lamp,
    input  wire logic                     log_valid,
    input  wire logic [15:0]              log_cause,
    input  wire logic [15:0]              log_addr
);
    logic [4:0] ctrl_q;
    logic       ack_p;
    logic       ack_d;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // Shadow of the control word, seen from bus writes only
    always_ff @(posedge clk)
    begin
        if (srst)
            ctrl_q <= TFID_CTRL_RESET;
        else if (wr_en && addr == TFID_ADDR_CTRL)
            ctrl_q <= wdata[4:0];
    end

    // Handler returns written by firmware
    assign ack_p = wr_en && addr == TFID_ADDR_ACK && wdata[TFID_ACK_PROC_BIT];
    assign ack_d = wr_en && addr == TFID_ADDR_ACK && wdata[TFID_ACK_DIAG_BIT];

    a_lamp_rise: assert property ($rose(system_fault_lamp) |->
        fault_event_handler) else $error("lamp lit without diagnostic");
    a_diag_preempt: assert property (fault_event_handler |->
        !process_event_handler) else $error("process runs beside diag");
    a_diag_hold: assert property (fault_event_handler && !ack_d
        |=> fault_event_handler) else $error("diag dropped early");
    a_proc_hold: assert property (process_event_handler
        && !ack_p |=> process_event_handler || fault_event_handler)
        else $error("process request lost");
    a_log_dispatch: assert property ($rose(fault_event_handler)
        |-> log_valid) else $error("diag dispatch not logged");
    a_log_pulse: assert property (log_valid |=> !log_valid)
        else $error("log strobe too long");
    a_log_addr: assert property (log_valid
        |-> log_addr == MODULE_ADDR) else $error("wrong module address");
    a_cause_bits: assert property (log_valid
        |-> log_cause[7:4] == 4'h0 && !log_cause[1] &&
        log_cause[15:8] inside {8'h40, 8'h00}) else $error("bad log cause");
    a_diag_gated: assert property (
        $rose(fault_event_handler) |-> ctrl_q[4] && ctrl_q[2] &&
        ctrl_q[1:0] != 2'h0) else $error("diag raised while not enabled");
    a_proc_gated: assert property (
        $rose(process_event_handler) |-> ctrl_q[3] && ctrl_q[2] &&
        (ctrl_q[1:0] == TFID_FUNC_COUNT || ctrl_q[1:0] == TFID_FUNC_FREQ))
        else $error("process not enabled");

    // Main scenarios reached
    c_proc: cover property ($rose(process_event_handler));
    c_incoming: cover property ($rose(fault_event_handler) && system_fault_lamp);
    c_lamp_off: cover property ($fell(system_fault_lamp));
endmodule

bind tfid_irq_ctrl tfid_irq_chk #(.MODULE_ADDR(MODULE_ADDR)) tfid_irq_chk_i
(
    .clk, .srst, .din_pin, .meas_done, .module_fail, .ext_error, .addr,
    .wdata, .wr_en, .rd_en, .rdata, .process_event_handler,
    .fault_event_handler, .system_fault_lamp, .log_valid, .log_cause,
    .log_addr
);

/* File: bench/tfid_fw_model.sv */
// Firmware model: returns from each handler after a set run time
`timescale 1ns/1ps
module tfid_fw_model
    import tfid_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [7:0]  dly,
    input  wire logic        process_event_handler,
    input  wire logic        fault_event_handler,
    output logic             fw_wr,
    output logic      [7:0]  fw_addr,
    output logic      [31:0] fw_wdata
);
    logic [7:0] p_cnt;
    logic [7:0] d_cnt;

    // Run time per routine; a pre-empted routine starts over
    always_ff @(posedge clk)
    begin
        if (srst || !process_event_handler)
            p_cnt <= 8'h00;
        else if (p_cnt != 8'hff)
            p_cnt <= p_cnt + 8'h01;
        if (srst || !fault_event_handler)
            d_cnt <= 8'h00;
        else if (d_cnt != 8'hff)
            d_cnt <= d_cnt + 8'h01;
    end

    // One return write per run; the diagnostic routine wins a tie
    always_ff @(posedge clk)
    begin
        fw_wr <= 1'b0;
        fw_addr <= TFID_ADDR_ACK;
        fw_wdata <= 32'h0;
        if (!srst && fault_event_handler && d_cnt == dly)
        begin
            fw_wr <= 1'b1;
            fw_wdata <= 32'h1 << TFID_ACK_DIAG_BIT;
        end
        else if (!srst && process_event_handler && p_cnt == dly)
        begin
            fw_wr <= 1'b1;
            fw_wdata <= 32'h1 << TFID_ACK_PROC_BIT;
        end
    end
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the technology-function interrupt block
`timescale 1ns/1ps
module testbench;
    import tfid_pkg::*;
    localparam logic [15:0] MADDR = 16'h0123; // Arbitrary module address
    logic        clk, srst, tb_wr, rd_en, fw_wr, module_fail, ext_error;
    logic        proc, fault, lamp, log_valid;
    logic [15:0] din_pin, log_cause, log_addr;
    logic [2:0]  meas_done;
    logic [7:0]  tb_addr, fw_addr, fw_dly, f;
    logic [31:0] tb_wdata, fw_wdata, rdata, rd, ex;
    int          error_cnt, n_checks, cyc, seed, k;

    // Firmware takes the bus only for its return strobes
    wire logic [7:0]  addr  = fw_wr ? fw_addr : tb_addr;
    wire logic [31:0] wdata = fw_wr ? fw_wdata : tb_wdata;
    wire logic        wr_en = fw_wr | tb_wr;

    tfid_irq_ctrl #(.MODULE_ADDR(MADDR)) tfid_irq_ctrl_i
    (
        .clk, .srst, .din_pin, .meas_done, .module_fail, .ext_error, .addr,
        .wdata, .wr_en, .rd_en, .rdata, .process_event_handler(proc),
        .fault_event_handler(fault), .system_fault_lamp(lamp), .log_valid,
        .log_cause, .log_addr
    );

    tfid_fw_model tfid_fw_model_i
    (
        .clk, .srst, .dly(fw_dly), .process_event_handler(proc),
        .fault_event_handler(fault), .fw_wr, .fw_addr, .fw_wdata
    );

    // 50 ns clock and a cycle ceiling against hangs
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            end_sim;
        end
    end

    task end_sim;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        tb_wr <= 1'b1;
        tb_addr <= a;
        tb_wdata <= d;
        @(posedge clk);
        tb_wr <= 1'b0;
    endtask

    task bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd_en <= 1'b1;
        tb_addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Event on input k, or end of measurement k-16
    task ev(input int k);
        @(posedge clk);
        if (k < 16)
            din_pin[k] <= ~din_pin[k];
        else
            meas_done[k - 16] <= 1'b1;
        @(posedge clk);
        meas_done <= 3'h0;
    endtask

    // Bounded wait for a handler level (sel 1 = diagnostic)
    task wait_sig(input logic sel, input logic lvl, input int lim);
        int i;
        i = 0;
        while ((sel ? fault : proc) !== lvl && i < lim)
        begin
            @(posedge clk);
            #1;
            i++;
        end
        check(sel ? fault : proc, lvl);
    endtask

    function automatic logic [31:0] exp_det(input int k);
        return k < 16 ? 32'h1 << k : 32'h1 << (16 + 4 * (k - 16));
    endfunction

    function automatic logic [31:0] exp_rec(input logic [7:0] f, logic inc);
        return {inc ? 8'h40 : 8'h00, 8'h00, 8'h1f,
                4'h0, inc, f[1], 1'b0, f[0]};
    endfunction

    initial
    begin
        seed = 32'hccb5;
        {srst, tb_wr, rd_en, module_fail, ext_error} = 5'h10;
        {tb_addr, tb_wdata, din_pin, meas_done} = '0;
        fw_dly = 8'd8;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        // Idle, write-only and unmapped words read zero
        for (k = 0; k < 7; k++)
        begin
            bus_rd(8'(k * 4), rd);
            check(rd, 32'h0);
        end
        // Frequency mode: edges on inputs 0 and 15, random channels, and every end-of-measurement detail bit
        bus_wr(TFID_ADDR_CTRL, 32'h1e);
        for (int i = 0; i < 10; i++)
        begin
            k = i < 5 ? (i == 0 ? 0 : 14 + i) : $unsigned($random(seed)) % 19;
            ev(k);
            wait_sig(1'b0, 1'b1, 12);
            bus_rd(TFID_ADDR_DETAIL, rd);
            check(rd, exp_det(k));
            wait_sig(1'b0, 1'b0, 20);
        end
        // Repeat on a busy channel escalates; other channels wait
        fw_dly <= 8'd40;
        f = 8'($random(seed));
        {ext_error, module_fail} <= f[1:0];
        ex = exp_rec(f, 1'b1);
        ev(3);
        wait_sig(1'b0, 1'b1, 12);
        ev(3);
        wait_sig(1'b1, 1'b1, 12);
        check(proc, 1'b0);
        check(lamp, 1'b1);
        check({log_valid, log_cause, log_addr[14:0]},
              {1'b1, ex[31:24], ex[7:0], MADDR[14:0]});
        bus_rd(TFID_ADDR_REC0, rd);
        check(rd, ex);
        ev(3);
        ev(5);
        wait_sig(1'b1, 1'b0, 60);
        wait_sig(1'b1, 1'b1, 80);
        bus_rd(TFID_ADDR_REC0, rd);
        check(rd, exp_rec(f, 1'b0));
        check(lamp, 1'b0);
        wait_sig(1'b0, 1'b1, 80);
        bus_rd(TFID_ADDR_DETAIL, rd);
        check(rd, 32'h20);
        wait_sig(1'b0, 1'b0, 60);
        repeat (20) @(posedge clk);
        bus_rd(TFID_ADDR_PEND, rd);
        check(rd, 32'h0);
        {module_fail, ext_error} <= 2'h0;
        // Diagnostics off: repeat is recorded but raises nothing
        bus_wr(TFID_ADDR_CTRL, 32'h0e);
        fw_dly <= 8'd30;
        ev(7);
        wait_sig(1'b0, 1'b1, 12);
        ev(7);
        repeat (8) @(posedge clk);
        check(fault, 1'b0);
        bus_rd(TFID_ADDR_REC0, rd);
        check(rd[31:24], 8'h40);
        wait_sig(1'b0, 1'b0, 40);
        // Pulse width, count without option, then count enabled
        for (int i = 0; i < 3; i++)
        begin
            bus_wr(TFID_ADDR_CTRL, i == 0 ? 32'h1f : i == 1 ? 32'h19 : 32'h1d);
            ev(2);
            repeat (10) @(posedge clk);
            check(proc, i == 2);
        end
        wait_sig(1'b0, 1'b0, 40);
        end_sim;
    end
endmodule
